// >>> hw/ppd_pad_pulldown.sv
// pad pulldown control register with wishbone slave and pad enables
// assumes one 100 MHz clock, synchronous reset, compat level from a pin
`include "ppd_params.svh"
`timescale 1ns/1ns

module ppd_pad_pulldown (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 compat_mode_i,
  output ppd_pkg::ppd_pad_pd_s      pad_pd_en_o
);

  ppd_pkg::ppd_wb_req_s req;
  logic [31:0]          ctrl_q;
  logic                 compat_meta_q;
  logic                 compat_q;
  logic                 access;

  function automatic logic ctrl_hit(input logic [31:0] adr);
    ctrl_hit = ((adr & `PPD_ADDR_MASK) == `PPD_CTRL0_OFFSET);
  endfunction : ctrl_hit

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  assign req    = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                    sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
  // ack falls after one cycle, so a held request is taken again every second cycle
  assign access = req.cyc & req.stb & ~wb_ack_o;

  // the compat level comes from a pin, so it is synchronised first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compat_meta_q <= 1'b0;
      compat_q      <= 1'b0;
    end else begin
      compat_meta_q <= compat_mode_i;
      compat_q      <= compat_meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // reserved bits are never stored, so a careless write cannot leak
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `PPD_CTRL0_RESET;
    end else if (access && req.we && ctrl_hit(req.adr)) begin
      ctrl_q <= (ctrl_q & ~(lane_mask(req.sel) & `PPD_CTRL0_WR_MASK))
              | (req.dat & lane_mask(req.sel) & `PPD_CTRL0_WR_MASK);
    end
  end

  // reads return the stored bits, not the forced pad state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !req.we && ctrl_hit(req.adr)) begin
      wb_dat_o <= ctrl_q & `PPD_CTRL0_WR_MASK;
    end else if (access) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // enable is the stored bit inverted, boot select also forced on by compat_q; one cycle behind the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_pd_en_o <= '1;
    end else begin
      pad_pd_en_o.serport3_tx_clock_pad <= ~ctrl_q[`PPD_BIT_SP3_TXCLK];
      pad_pd_en_o.camera_hsync_pad      <= ~ctrl_q[`PPD_BIT_CAM_HSYNC];
      pad_pd_en_o.boot_select_pad       <= ~ctrl_q[`PPD_BIT_BOOT_SEL]
                                           | compat_q;
      pad_pd_en_o.emulation_line_1      <= ~ctrl_q[`PPD_BIT_EMULATION_LINE_1];
      pad_pd_en_o.emulation_line_0      <= ~ctrl_q[`PPD_BIT_EMULATION_LINE_0];
      pad_pd_en_o.cam_data2_pad         <= ~ctrl_q[`PPD_BIT_CAM_D2];
      pad_pd_en_o.cam_data3_pad         <= ~ctrl_q[`PPD_BIT_CAM_D3];
      pad_pd_en_o.cam_data5_pad         <= ~ctrl_q[`PPD_BIT_CAM_D5];
      pad_pd_en_o.serport1_rx_data_pad  <= ~ctrl_q[`PPD_BIT_SP1_RXDATA];
    end
  end

endmodule : ppd_pad_pulldown

// >>> hw/ppd_params.svh
// offsets, field positions and reset values of the pad pulldown block
// assumes a 32-bit classic wishbone register port
`ifndef PPD_PARAMS_SVH
`define PPD_PARAMS_SVH

`define PPD_CTRL0_OFFSET    32'h0000_0000
`define PPD_CTRL0_RESET     32'h0000_0000
// bits that hold storage; every other bit is reserved and reads zero
`define PPD_CTRL0_WR_MASK   32'h3fb1_0000
`define PPD_ADDR_MASK       32'h0000_00fc

`define PPD_BIT_SP3_TXCLK   29
`define PPD_BIT_CAM_HSYNC   28
`define PPD_BIT_BOOT_SEL    27
`define PPD_BIT_EMULATION_LINE_1        26
`define PPD_BIT_EMULATION_LINE_0        25
`define PPD_BIT_CAM_D2      24
`define PPD_BIT_CAM_D3      23
`define PPD_BIT_CAM_D5      21
`define PPD_BIT_SP1_RXDATA  16

`endif

// >>> hw/ppd_pkg.sv
// types shared by the pad pulldown block
// assumes ppd_params.svh holds the numbers
package ppd_pkg;

  // one pulldown enable per pad, 1 = resistor switched in
  typedef struct packed {
    logic serport3_tx_clock_pad;
    logic camera_hsync_pad;
    logic boot_select_pad;
    logic emulation_line_1;
    logic emulation_line_0;
    logic cam_data2_pad;
    logic cam_data3_pad;
    logic cam_data5_pad;
    logic serport1_rx_data_pad;
  } ppd_pad_pd_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } ppd_wb_req_s;

endpackage : ppd_pkg

// >>> sim/ppd_sva.sv
// port checker for the pad pulldown block; assumes full-lane writes
`timescale 1ns/1ns
module ppd_sva (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_we_i,
  input wire logic [31:0]          wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 compat_mode_i,
  input wire ppd_pkg::ppd_pad_pd_s pad_pd_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [8:0]  p = pad_pd_en_o;
  wire [31:0] d = wb_dat_i;
  wire        w = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h0;
  property p_rs; disable iff (1'b0) rst_i |=> p == 9'h1ff; endproperty
  a_rs: assert property (p_rs) else $error("rst");
  property p_hs; w |=> p[7] != $past(d[28]); endproperty
  a_hs: assert property (p_hs) else $error("hs");
  property p_cd; w |=> p[3:1] == ~$past({d[24:23], d[21]}); endproperty
  a_cd: assert property (p_cd) else $error("cam");
  property p_rx; w |=> p[0] != $past(d[16]); endproperty
  a_rx: assert property (p_rx) else $error("rx");
  property p_tx; w |=> p[8] != $past(d[29]); endproperty
  a_tx: assert property (p_tx) else $error("tx");
  property p_bt; compat_mode_i [*4] |-> p[6]; endproperty
  a_bt: assert property (p_bt) else $error("boot");
  property p_em; w |=> p[5:4] == ~$past(d[26:25]); endproperty
  a_em: assert property (p_em) else $error("emu");
  property p_rd; wb_ack_o |-> wb_we_i || !(wb_dat_o & 32'hc04e_ffff);
  endproperty
  a_rd: assert property (p_rd) else $error("rsv");
endmodule : ppd_sva
bind ppd_pad_pulldown ppd_sva ppd_sva_i (.*);

// >>> sim/test_ppd_pad_pulldown.sv
// random register traffic against a model; assumes package and checker
`timescale 1ns/1ns
module test_ppd_pad_pulldown;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_we_i = 0, wb_ack_o;
  logic        compat_mode_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, m = 0, x = 32'ha515;
  logic [3:0]  wb_sel_i = 4'hf;
  wire         wb_stb_i = wb_cyc_i;
  ppd_pkg::ppd_pad_pd_s pad_pd_en_o;
  int          err_total = 0, checks_done = 0;
  wire [8:0]   e = {~m[29:28], ~m[27] | compat_mode_i, ~m[26:23],
                    ~m[21], ~m[16]};
  ppd_pad_pulldown ppd_pad_pulldown_i (.*);
  initial forever #5 clk_i = ~clk_i;
  task automatic ck(logic [31:0] g, logic [31:0] v);
    checks_done++;
    err_total += int'(g !== v);
    if (g !== v) $display("MISMATCH %0t got %h want %h", $time, g, v);
  endtask : ck
  task automatic bus(logic [1:0] w, logic [31:0] a);
    // software keeps reserved bits zero on every write
    @(posedge clk_i) {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <=
                     {w, a, x & 32'h3fb1_0000};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
  endtask : bus
  task automatic give_verdict(int t);
    err_total += t;
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial #20us give_verdict(1);
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    ck(pad_pd_en_o, 32'h0000_01ff);
    bus(2'b10, 7'h00);
    ck(wb_dat_o, 32'h0000_0000);
    repeat (60) begin
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      compat_mode_i <= x[30];
      bus(2'b11, {x[31], 6'h0});
      if (!x[31]) m = x & 32'h3fb1_0000;
      bus(2'b10, {x[29], 6'h0});
      ck(wb_dat_o, x[29] ? 32'h0 : m);
      ck(pad_pd_en_o, e);
    end
    give_verdict(0);
  end
endmodule : test_ppd_pad_pulldown
